// *** hdl/txsel_cfg.svh ***
// offsets, field positions and reset values of the transmit source selector
`ifndef TXSEL_CFG_SVH
`define TXSEL_CFG_SVH
`define TXSEL_ADDR_W 8
`define TXSEL_SOURCE_OFFSET 8'h16
`define TXSEL_DRIVER_CTRL_OFFSET 8'h20
`define TXSEL_TEST_SELECT_OFFSET 8'h24
`define TXSEL_SOURCE_RESET 8'h10
`define TXSEL_DRIVER_CTRL_RESET 8'h00
`define TXSEL_TEST_SELECT_RESET 8'h00
`define TXSEL_SOURCE_WMASK 8'h3F
`define TXSEL_DRV_LSB 4
`define TXSEL_DRV_MSB 5
`define TXSEL_SIG_LSB 0
`define TXSEL_SIG_MSB 3
`define TXSEL_CTRL_D1_EN 0
`define TXSEL_CTRL_D2_EN 1
`define TXSEL_CTRL_D1_INV_OFF 4
`define TXSEL_CTRL_D2_INV_OFF 5
`define TXSEL_CTRL_D1_INV_ON 6
`define TXSEL_CTRL_D2_INV_ON 7
`define TXSEL_CTRL_SOFT_PD 3
`define TXSEL_TEST_BIT_LSB 0
`define TXSEL_TEST_BIT_MSB 2
`endif

// *** hdl/txsel_pkg.sv ***
// types of the transmit source selector
`default_nettype none
package txsel_pkg;
   typedef enum logic [1:0] {
      DRV_TRISTATE = 2'h0,
      DRV_CODER = 2'h1,
      DRV_SIGNAL_IN = 2'h2,
      DRV_HIGH = 2'h3
   } driver_source_e;
   typedef enum logic [3:0] {
      SO_TRISTATE = 4'h0, SO_LOW = 4'h1, SO_HIGH = 4'h2, SO_TEST_BUS = 4'h3,
      SO_CODER_ENV = 4'h4, SO_TX_STREAM = 4'h5, SO_RX_REGEN = 4'h6, SO_RX_STREAM = 4'h7,
      SO_B_RX = 4'h8, SO_B_TX = 4'h9, SO_B_COMPARATOR = 4'hA, SO_B_RESERVED = 4'hB,
      SO_A_RX_CARRIER = 4'hC, SO_A_TX_CARRIER = 4'hD, SO_A_RX_UNFILTERED = 4'hE, SO_A_RX_ENVELOPE = 4'hF
   } signal_out_source_e;
endpackage
`default_nettype wire

// *** hdl/txsel_pin_sync.sv ***
// two flip-flop synchroniser for a bundle of pin inputs
`default_nettype none
module txsel_pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_sync
);
   if (WIDTH < 1)
   begin : g_width_check
      $error("width must be at least one");
   end
   logic [WIDTH-1:0] stage_reg;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] stage_next;
   logic [WIDTH-1:0] sync_next;
   always_comb
   begin
      stage_next = pin_in;
      sync_next = stage_reg;
   end
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         stage_reg <= '0;
         sync_reg <= '0;
      end
      else
      begin
         stage_reg <= stage_next;
         sync_reg <= sync_next;
      end
   end
   assign pin_sync = sync_reg;
endmodule
`default_nettype wire

// *** hdl/txsel_driver_stage.sv ***
// one antenna driver: source pick, inversion and enable
`default_nettype none
module txsel_driver_stage (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [1:0] driver_source,
   input wire logic coder_env,
   input wire logic signal_in_env,
   input wire logic driver_enable,
   input wire logic invert_when_on,
   input wire logic invert_when_off,
   output logic drive_out,
   output logic drive_oe
);
   logic out_reg;
   logic oe_reg;
   logic out_next;
   logic oe_next;
   logic raw;
   logic invert;
   always_comb
   begin
      raw = 1'b0;
      case (txsel_pkg::driver_source_e'(driver_source))
         txsel_pkg::DRV_CODER: raw = coder_env;
         txsel_pkg::DRV_SIGNAL_IN: raw = signal_in_env;
         txsel_pkg::DRV_HIGH: raw = 1'b1;
         default: raw = 1'b0;
      endcase
      // inversion applies also to the constant high code [RULE3]
      invert = driver_enable ? invert_when_on : invert_when_off; // [RULE15]
      out_next = raw ^ invert;
      // tristate only by the tristate code, also in soft power-down [RULE2]
      oe_next = (driver_source != 2'h0);
   end
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         out_reg <= 1'b0;
         oe_reg <= 1'b1;
      end
      else
      begin
         out_reg <= out_next;
         oe_reg <= oe_next;
      end
   end
   assign drive_out = out_reg;
   assign drive_oe = oe_reg;
endmodule
`default_nettype wire

// *** hdl/transmit_source_select_mux.sv ***
// transmit source selector with its wishbone register file
// How it works
// (RULE1) bits 5:4 pick shared antenna driver source
// (RULE2) soft power-down tristates drivers only on 00
// (RULE3) constant high follows each driver's inversion bits
// (RULE4) signal-out codes 0000 float, 0001 low, 0010 high
// (RULE5) code 0011 outputs selected test-bus line
// (RULE6) 0100 coder envelope, 0101 transmit bit stream
// (RULE7) 0110 regenerated delayed card modulation
// (RULE8) 0111 decoded received serial stream
// (RULE9) 1000-1010 second family secure signals, 1011 reserved
// (RULE10) 1100-1111 type-A secure signals with carrier
// (RULE11) software enters receive mode before using receive outputs
// (RULE12) software avoids 0110/0111 in type-A card mode
// (RULE13) bits 7:6 read zero, select nothing
// (RULE14) register at 16h, resets to 10h
// (RULE15) driver inversion bit chosen by enable state
// (RULE16) new selection acts from next clock cycle
`include "txsel_cfg.svh"
`default_nettype none
module transmit_source_select_mux #(
   parameter int TEST_BUS_W = 8
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic signal_in_pin,
   input wire logic coder_envelope,
   input wire logic tx_bit_stream,
   input wire logic rx_regenerated,
   input wire logic rx_bit_stream,
   input wire logic [TEST_BUS_W-1:0] test_bus,
   input wire logic b_sam_rx,
   input wire logic b_sam_tx,
   input wire logic b_sam_comparator,
   input wire logic a_sam_rx_carrier,
   input wire logic a_sam_tx_carrier,
   input wire logic a_sam_rx_unfiltered,
   input wire logic a_sam_rx_envelope,
   output logic antenna_driver_one,
   output logic antenna_driver_one_oe,
   output logic antenna_driver_two,
   output logic antenna_driver_two_oe,
   output logic signal_out_pin,
   output logic signal_out_pin_oe
);
   if (TEST_BUS_W < 1 || TEST_BUS_W > 8)
   begin : g_width_check
      $error("test bus width must be 1 to 8");
   end

   function automatic logic hit(input logic [7:0] adr, input logic [7:0] offs);
      hit = (adr[7:2] == offs[7:2]);
   endfunction

   logic [7:0] source_reg;
   logic [7:0] source_next;
   logic [7:0] ctrl_reg;
   logic [7:0] ctrl_next;
   logic [7:0] test_reg;
   logic [7:0] test_next;
   logic ack_reg;
   logic ack_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic sig_reg;
   logic sig_next;
   logic sig_oe_reg;
   logic sig_oe_next;
   logic sig_in_sync;
   logic req;
   logic wr;
   logic [2:0] test_bit;

   txsel_pin_sync #(.WIDTH(1)) u_sig_in_sync (
      .core_clk(core_clk),
      .resetn(resetn),
      .pin_in(signal_in_pin),
      .pin_sync(sig_in_sync)
   );

   // register file: one word answer per request, ack one cycle after strobe
   always_comb
   begin
      req = wb_cyc_i && wb_stb_i && !ack_reg;
      wr = req && wb_we_i && wb_sel_i[0];
      source_next = source_reg;
      ctrl_next = ctrl_reg;
      test_next = test_reg;
      if (wr && hit(wb_adr_i, `TXSEL_SOURCE_OFFSET))
         source_next = wb_dat_i[7:0] & `TXSEL_SOURCE_WMASK; // [RULE13] [RULE16]
      if (wr && hit(wb_adr_i, `TXSEL_DRIVER_CTRL_OFFSET))
         ctrl_next = wb_dat_i[7:0];
      if (wr && hit(wb_adr_i, `TXSEL_TEST_SELECT_OFFSET))
         test_next = wb_dat_i[7:0];
      ack_next = req;
      rdata_next = rdata_reg;
      if (req && !wb_we_i)
      begin
         if (hit(wb_adr_i, `TXSEL_SOURCE_OFFSET))
            rdata_next = {24'h000000, source_reg}; // [RULE13]
         else if (hit(wb_adr_i, `TXSEL_DRIVER_CTRL_OFFSET))
            rdata_next = {24'h000000, ctrl_reg};
         else if (hit(wb_adr_i, `TXSEL_TEST_SELECT_OFFSET))
            rdata_next = {24'h000000, test_reg};
         else
            rdata_next = 32'h00000000;
      end
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         source_reg <= `TXSEL_SOURCE_RESET; // [RULE14]
         ctrl_reg <= `TXSEL_DRIVER_CTRL_RESET;
         test_reg <= `TXSEL_TEST_SELECT_RESET;
         ack_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
      end
      else
      begin
         source_reg <= source_next;
         ctrl_reg <= ctrl_next;
         test_reg <= test_next;
         ack_reg <= ack_next;
         rdata_reg <= rdata_next;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdata_reg;

   // antenna drivers share one source [RULE1]
   txsel_driver_stage u_driver_one (
      .core_clk(core_clk),
      .resetn(resetn),
      .driver_source(source_reg[`TXSEL_DRV_MSB:`TXSEL_DRV_LSB]),
      .coder_env(coder_envelope),
      .signal_in_env(sig_in_sync),
      .driver_enable(ctrl_reg[`TXSEL_CTRL_D1_EN]),
      .invert_when_on(ctrl_reg[`TXSEL_CTRL_D1_INV_ON]),
      .invert_when_off(ctrl_reg[`TXSEL_CTRL_D1_INV_OFF]),
      .drive_out(antenna_driver_one),
      .drive_oe(antenna_driver_one_oe)
   );

   txsel_driver_stage u_driver_two (
      .core_clk(core_clk),
      .resetn(resetn),
      .driver_source(source_reg[`TXSEL_DRV_MSB:`TXSEL_DRV_LSB]),
      .coder_env(coder_envelope),
      .signal_in_env(sig_in_sync),
      .driver_enable(ctrl_reg[`TXSEL_CTRL_D2_EN]),
      .invert_when_on(ctrl_reg[`TXSEL_CTRL_D2_INV_ON]),
      .invert_when_off(ctrl_reg[`TXSEL_CTRL_D2_INV_OFF]),
      .drive_out(antenna_driver_two),
      .drive_oe(antenna_driver_two_oe)
   );

   // signal-out pin multiplexer
   always_comb
   begin
      test_bit = test_reg[`TXSEL_TEST_BIT_MSB:`TXSEL_TEST_BIT_LSB];
      sig_next = 1'b0;
      sig_oe_next = 1'b1;
      case (txsel_pkg::signal_out_source_e'(source_reg[`TXSEL_SIG_MSB:`TXSEL_SIG_LSB]))
         txsel_pkg::SO_TRISTATE: sig_oe_next = 1'b0; // [RULE4]
         txsel_pkg::SO_LOW: sig_next = 1'b0; // [RULE4]
         txsel_pkg::SO_HIGH: sig_next = 1'b1; // [RULE4]
         txsel_pkg::SO_TEST_BUS: sig_next = (32'(test_bit) < TEST_BUS_W) ? test_bus[test_bit] : 1'b0; // [RULE5]
         txsel_pkg::SO_CODER_ENV: sig_next = coder_envelope; // [RULE6]
         txsel_pkg::SO_TX_STREAM: sig_next = tx_bit_stream; // [RULE6]
         txsel_pkg::SO_RX_REGEN: sig_next = rx_regenerated; // [RULE7]
         txsel_pkg::SO_RX_STREAM: sig_next = rx_bit_stream; // [RULE8]
         txsel_pkg::SO_B_RX: sig_next = b_sam_rx; // [RULE9]
         txsel_pkg::SO_B_TX: sig_next = b_sam_tx; // [RULE9]
         txsel_pkg::SO_B_COMPARATOR: sig_next = b_sam_comparator; // [RULE9]
         txsel_pkg::SO_B_RESERVED: sig_next = 1'b0; // [RULE9]
         txsel_pkg::SO_A_RX_CARRIER: sig_next = a_sam_rx_carrier; // [RULE10]
         txsel_pkg::SO_A_TX_CARRIER: sig_next = a_sam_tx_carrier; // [RULE10]
         txsel_pkg::SO_A_RX_UNFILTERED: sig_next = a_sam_rx_unfiltered; // [RULE10]
         txsel_pkg::SO_A_RX_ENVELOPE: sig_next = a_sam_rx_envelope; // [RULE10]
         default: sig_next = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sig_reg <= 1'b0;
         sig_oe_reg <= 1'b0;
      end
      else
      begin
         sig_reg <= sig_next;
         sig_oe_reg <= sig_oe_next;
      end
   end

   assign signal_out_pin = sig_reg;
   assign signal_out_pin_oe = sig_oe_reg;

   // field views for the checks; sampled reset in antecedents skips the release edge
   logic [3:0] sig_code;
   logic [1:0] drv_code;
   assign sig_code = source_reg[`TXSEL_SIG_MSB:`TXSEL_SIG_LSB];
   assign drv_code = source_reg[`TXSEL_DRV_MSB:`TXSEL_DRV_LSB];

   a_reserved_zero: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE13]
      source_reg[7:6] == 2'h0)
      else $error("reserved source bits not zero");

   a_source_write_next: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE16]
      (resetn && wr && hit(wb_adr_i, `TXSEL_SOURCE_OFFSET)) |=>
         source_reg == (8'($past(wb_dat_i)) & `TXSEL_SOURCE_WMASK))
      else $error("source write not taken next cycle");

   a_ack_one_cycle: assert property (@(posedge core_clk) disable iff (!resetn)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");

   a_signal_out_pin_tristate: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE4]
      (resetn && sig_code == 4'h0) |=> !signal_out_pin_oe)
      else $error("signal out not floating on code 0");

   a_signal_out_pin_low: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE4]
      (resetn && sig_code == 4'h1) |=> (!signal_out_pin && signal_out_pin_oe))
      else $error("signal out not low on code 1");

   a_signal_out_pin_high: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE4]
      (resetn && sig_code == 4'h2) |=> (signal_out_pin && signal_out_pin_oe))
      else $error("signal out not high on code 2");

   a_signal_out_pin_coder: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE6]
      (resetn && sig_code == 4'h4) |=> signal_out_pin == $past(coder_envelope))
      else $error("coder envelope not routed");

   a_signal_out_pin_txstream: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE6]
      (resetn && sig_code == 4'h5) |=> signal_out_pin == $past(tx_bit_stream))
      else $error("transmit stream not routed");

   a_signal_out_pin_regen: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE7]
      (resetn && sig_code == 4'h6) |=> signal_out_pin == $past(rx_regenerated))
      else $error("regenerated modulation not routed");

   a_signal_out_pin_rxstream: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE8]
      (resetn && sig_code == 4'h7) |=> signal_out_pin == $past(rx_bit_stream))
      else $error("received stream not routed");

   a_signal_out_pin_brx: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE9]
      (resetn && sig_code == 4'h8) |=> signal_out_pin == $past(b_sam_rx))
      else $error("second family receive not routed");

   a_signal_out_pin_btx: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE9]
      (resetn && sig_code == 4'h9) |=> signal_out_pin == $past(b_sam_tx))
      else $error("second family transmit not routed");

   a_signal_out_pin_bcomp: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE9]
      (resetn && sig_code == 4'hA) |=> signal_out_pin == $past(b_sam_comparator))
      else $error("comparator output not routed");

   a_signal_out_pin_reserved: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE9]
      (resetn && sig_code == 4'hB) |=> (!signal_out_pin && signal_out_pin_oe))
      else $error("reserved code not driving low");

   a_signal_out_pin_acarrier: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE10]
      (resetn && sig_code == 4'hC) |=> signal_out_pin == $past(a_sam_rx_carrier))
      else $error("type-A receive with carrier not routed");

   a_signal_out_pin_atx: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE10]
      (resetn && sig_code == 4'hD) |=> signal_out_pin == $past(a_sam_tx_carrier))
      else $error("type-A transmit with carrier not routed");

   a_signal_out_pin_aunfilt: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE10]
      (resetn && sig_code == 4'hE) |=> signal_out_pin == $past(a_sam_rx_unfiltered))
      else $error("type-A unfiltered receive not routed");

   a_signal_out_pin_arx: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE10]
      (resetn && sig_code == 4'hF) |=> signal_out_pin == $past(a_sam_rx_envelope))
      else $error("type-A envelope not routed");

   a_driver_float: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE2]
      (resetn && drv_code == 2'h0) |=> !antenna_driver_one_oe && !antenna_driver_two_oe)
      else $error("drivers not floating on tristate code");

   a_driver_driven: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE2]
      (resetn && drv_code != 2'h0) |=> antenna_driver_one_oe && antenna_driver_two_oe)
      else $error("drivers floating on a driven code");

   a_driver_high: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE3]
      (resetn && drv_code == 2'h3) |=> antenna_driver_one ==
         !($past(ctrl_reg[0]) ? $past(ctrl_reg[6]) : $past(ctrl_reg[4])))
      else $error("driver one high level wrong");

   a_driver_coder: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE1]
      (resetn && drv_code == 2'h1) |=> antenna_driver_two ==
         ($past(coder_envelope) ^ ($past(ctrl_reg[1]) ? $past(ctrl_reg[7]) : $past(ctrl_reg[5]))))
      else $error("driver two coder source wrong");

   a_driver_signal_in_pin: assert property (@(posedge core_clk) disable iff (!resetn) // [RULE1]
      (resetn && drv_code == 2'h2) |=> antenna_driver_one ==
         ($past(sig_in_sync) ^ ($past(ctrl_reg[0]) ? $past(ctrl_reg[6]) : $past(ctrl_reg[4]))))
      else $error("driver one signal-in source wrong");
endmodule
`default_nettype wire

// *** test/sam_model.sv ***
// external secure module on the signal-out pin, also drives signal-in
`default_nettype none
module sam_model (
   input wire logic core_clk,
   input wire logic env_req,
   input wire logic signal_out_pin,
   input wire logic signal_out_pin_oe,
   output logic signal_in_pin,
   output logic wire_level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic last_level = 1'b0;
   // released pin shows the inverse of the last driven level, not a stale copy
   assign wire_level = signal_out_pin_oe ? signal_out_pin : ~last_level;
   always @(posedge core_clk)
   begin
      if (signal_out_pin_oe)
         last_level <= signal_out_pin;
      signal_in_pin <= env_req;
   end
endmodule
`default_nettype wire

// *** test/test_transmit_source_select_mux.sv ***
// bench for the transmit source selector
`default_nettype none
module test_transmit_source_select_mux;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0, resetn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, env_req = 1'b0;
   logic [7:0] adr = 8'h00, tbus = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, dat_o;
   logic [3:0] sel = 4'h0;
   logic [10:0] src_v = 11'h000;
   logic ack, sig_in, d1, d1_oe, d2, d2_oe, so, so_oe, wire_lvl;
   int err_total = 0, total_checks = 0;
   always #5 core_clk = ~core_clk;
   transmit_source_select_mux dut (.core_clk(core_clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .signal_in_pin(sig_in), .coder_envelope(src_v[0]), .tx_bit_stream(src_v[1]), .rx_regenerated(src_v[2]),
      .rx_bit_stream(src_v[3]), .test_bus(tbus), .b_sam_rx(src_v[4]), .b_sam_tx(src_v[5]),
      .b_sam_comparator(src_v[6]), .a_sam_rx_carrier(src_v[7]), .a_sam_tx_carrier(src_v[8]),
      .a_sam_rx_unfiltered(src_v[9]), .a_sam_rx_envelope(src_v[10]), .antenna_driver_one(d1),
      .antenna_driver_one_oe(d1_oe), .antenna_driver_two(d2), .antenna_driver_two_oe(d2_oe),
      .signal_out_pin(so), .signal_out_pin_oe(so_oe));
   sam_model partner (.core_clk(core_clk), .env_req(env_req), .signal_out_pin(so), .signal_out_pin_oe(so_oe),
      .signal_in_pin(sig_in), .wire_level(wire_lvl));
   task automatic summarize();
      if (err_total == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge core_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1)
      begin
         err_total++;
         summarize();
      end
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic t_access();
      wb(1'b0, 8'h16, 32'h0, 4'hF);
      chk("source reset", rdat, 32'h10);
      wb(1'b0, 8'h20, 32'h0, 4'hF);
      chk("ctrl reset", rdat, 32'h0);
      wb(1'b1, 8'h16, 32'hFF, 4'hF);
      wb(1'b1, 8'h16, 32'h01, 4'hE);
      wb(1'b0, 8'h16, 32'h0, 4'hF);
      chk("source masked", rdat, 32'h3F);
      wb(1'b1, 8'h40, 32'hFF, 4'hF);
      wb(1'b0, 8'h40, 32'h0, 4'hF);
      chk("unmapped", rdat, 32'h0);
   endtask
   function automatic logic so_exp(input logic [3:0] c, input logic [10:0] s, input logic tl);
      case (c)
         4'h1: return 1'b0;
         4'h2: return 1'b1;
         4'h3: return tl;
         4'hB: return 1'b0;
         default: return (c < 4'hB) ? s[c - 4'h4] : s[c - 4'h5];
      endcase
   endfunction
   task automatic t_signal_out_pin();
      logic [3:0] c;
      wb(1'b1, 8'h24, 32'h05, 4'hF);
      for (int i = 0; i < 32; i++)
      begin
         c = i[4:1];
         @(posedge core_clk);
         src_v <= i[0] ? 11'h2AA : 11'h555;
         tbus <= i[0] ? 8'hDF : 8'h20;
         wb(1'b1, 8'h16, {28'h1, c}, 4'hF);
         settle(1);
         chk("so_oe", so_oe, c != 4'h0);
         if (c != 4'h0)
         begin
            chk("so", so, so_exp(c, src_v, tbus[5]));
            chk("wire", wire_lvl, so_exp(c, src_v, tbus[5]));
         end
      end
   endtask
   task automatic t_driver();
      logic [7:0] ctl [5] = '{8'h00, 8'h30, 8'h43, 8'hC0, 8'h83};
      logic i1, i2;
      @(posedge core_clk);
      env_req <= 1'b1;
      wb(1'b1, 8'h16, 32'h20, 4'hF);
      settle(6);
      chk("d1 signal_in_pin", {d1, d2, d1_oe, d2_oe}, 4'hF);
      @(posedge core_clk);
      env_req <= 1'b0;
      settle(6);
      chk("d1 signal_in_pin low", {d1, d2}, 2'h0);
      wb(1'b1, 8'h16, 32'h00, 4'hF);
      settle(1);
      chk("tristate oe", {d1_oe, d2_oe}, 2'h0);
      wb(1'b1, 8'h16, 32'h30, 4'hF);
      foreach (ctl[k])
      begin
         wb(1'b1, 8'h20, {24'h0, ctl[k]}, 4'hF);
         settle(2);
         i1 = ctl[k][0] ? ctl[k][6] : ctl[k][4];
         i2 = ctl[k][1] ? ctl[k][7] : ctl[k][5];
         chk("high level", {d1, d2, d1_oe, d2_oe}, {~i1, ~i2, 2'h3});
      end
      @(posedge core_clk);
      src_v <= 11'h001;
      wb(1'b1, 8'h16, 32'h10, 4'hF);
      wb(1'b1, 8'h20, 32'h08, 4'hF);
      settle(2);
      chk("soft pd coder", {d1, d2, d1_oe, d2_oe}, 4'hF);
      wb(1'b1, 8'h20, 32'h41, 4'hF);
      settle(2);
      chk("coder invert", {d1, d2}, 2'h1);
   endtask
   task automatic t_reset();
      wb(1'b1, 8'h16, 32'h25, 4'hF);
      resetn <= 1'b0;
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      wb(1'b0, 8'h16, 32'h0, 4'hF);
      chk("source after reset", rdat, 32'h10);
      wb(1'b0, 8'h20, 32'h0, 4'hF);
      chk("ctrl after reset", rdat, 32'h0);
      settle(1);
      chk("outputs after reset", {so, so_oe, d1_oe, d2_oe}, 4'h3);
   endtask
   initial
   begin
      repeat (6) @(posedge core_clk);
      resetn <= 1'b1;
      t_access();
      t_signal_out_pin();
      t_driver();
      t_reset();
      summarize();
   end
endmodule
`default_nettype wire
